// File: hdl/pll_cal_pkg.sv
`default_nettype none
package pll_cal_pkg;
    // timing base
    localparam int CLK_MHZ        = 125;             // mclk rate in MHz
    localparam int US_CYCLES      = CLK_MHZ;         // mclk cycles per microsecond
    localparam int MS_US          = 1000;            // microseconds per millisecond
    localparam int SETTLE_STEP_US = 10;              // settling field step
    localparam int RC_CAL_MS      = 2;               // forced rc calibration length
    localparam int RC_CAL_US      = RC_CAL_MS * MS_US;
    localparam int FINE_CAL_S     = 30;              // rc fine calibration period
    localparam int FINE_CAL_MS    = FINE_CAL_S * 1000;
    localparam int PRE_MULT       = 4;               // preamble window multiplier
    // register indices; byte address is four times the index
    localparam logic [7:0] IDX_TUNE       = 8'h53;
    localparam logic [7:0] IDX_BOOST      = 8'h54;
    localparam logic [7:0] IDX_CAL        = 8'h55;
    localparam logic [7:0] IDX_IRQ_STATUS = 8'h60;
    localparam logic [7:0] IDX_IRQ_ENABLE = 8'h61;
    localparam logic [7:0] IDX_IRQ_CLEAR  = 8'h62;
    // reset values
    localparam logic [7:0] TUNE_RST  = 8'h52;
    localparam logic [7:0] BOOST_RST = 8'h54;
    localparam logic [7:0] CAL_RST   = 8'h44;
    // field positions
    localparam int TS_HI = 7, TS_LO = 3, TO_HI = 2, TO_LO = 0;
    localparam int PRE_HI = 5, PRE_LO = 2, REGB_BIT = 1, BIAS_BIT = 0;
    localparam int XHALF_BIT = 6, ADCDONE_BIT = 5, FINE_BIT = 4, RCCAL_BIT = 3;
    localparam int VDP_BIT = 2, VCOCAL_BIT = 1, SKIP_BIT = 0;
    // interrupt bits
    localparam int IRQ_W = 4;
    localparam int IRQ_VCO = 0, IRQ_RC = 1, IRQ_SETTLED = 2, IRQ_ADC = 3;
    localparam int SETTLE_W = 9;                     // up to 380 us
    localparam int CNT_W = 16;                       // slow counters

    // steering levels to the analog side
    typedef struct packed {
        logic       xtal_wake_half;
        logic       amp_regulator_boost;
        logic       amp_bias_boost;
        logic [5:0] preamble_window_bits;
        logic       skip_vco_cal;
        logic       vco_cal_double;
    } analog_ctrl_t;

    // levels from the chip's own state logic
    typedef struct packed {
        logic synth_enable;
        logic chip_idle;
        logic wake_timer_en;
        logic wake_on_rx;
        logic rc_osc_enabled;
        logic adc_cal_finished;
    } chip_state_t;

    typedef enum logic [1:0] {
        SYN_IDLE   = 2'b00,
        SYN_CAL    = 2'b01,
        SYN_SETTLE = 2'b10
    } syn_state_t;

    typedef enum logic [0:0] {
        RC_IDLE = 1'b0,
        RC_RUN  = 1'b1
    } rc_state_t;
endpackage
`default_nettype wire

// File: hdl/pll_tune_and_calibration_ctrl.sv
`default_nettype none
// Operation
// - cold start settles soft plus post-cal time
// - soft settle field: 10 us steps
// - post-cal settle field: 10 us steps
// - preamble window is threshold times four
// - half crystal wake time when set
// - adc cal done reads one when finished
// - fine rc calibration every 30 s
// - rising force bit: 2 ms rc cal, self-clear
// - auto rc cal on wake timer/wake-on-rx
// - rc cal only while rc oscillator on
// - double precision lengthens vco calibration
// - vco force in idle with synth on
// - skip vco cal on idle to tx/rx
module pll_tune_and_calibration_ctrl
    import pll_cal_pkg::*;
#(
    parameter int US_DIV         = US_CYCLES,    // cycles per microsecond tick
    parameter int RC_CAL_TICKS   = RC_CAL_US,    // rc cal length in us ticks
    parameter int FINE_CAL_TICKS = FINE_CAL_MS   // fine cal period in ms ticks
) (
    // clock and reset
    input  wire logic         mclk,
    input  wire logic         rst_n,
    // avalon-mm slave
    input  wire logic [9:0]   address,
    input  wire logic         read,
    input  wire logic         write,
    input  wire logic [31:0]  writedata,
    input  wire logic [3:0]   byteenable,
    output logic      [31:0]  readdata,
    output logic              waitrequest,
    // chip state and sequencer
    input  wire chip_state_t  chip_state,
    input  wire logic         txrx_req,
    input  wire logic         retune_req,
    input  wire logic         vco_cal_finished,
    // controls out
    output analog_ctrl_t      analog_ctrl,
    output logic              vco_cal_start,
    output logic              vco_cal_busy,
    output logic              synth_settled,
    output logic              rc_cal_active,
    output logic              rc_cal_fine,
    output logic              irq
);

    // linear: ten us per step
    function automatic logic [SETTLE_W-1:0] settle_us(input logic [4:0] steps);
        settle_us = SETTLE_W'(steps * SETTLE_STEP_US);
    endfunction

    // register contents
    logic [7:0]       tune_reg;       // settle fields
    logic [7:0]       boost_reg;      // preamble and boost bits
    logic             xtal_half;      // halved crystal wake
    logic             fine_en;        // fine rc cal enable
    logic             rc_force;       // forced rc cal pending or running
    logic             vco_double;     // double precision vco cal
    logic             vco_force;      // forced vco cal pending or running
    logic             skip_vco;       // skip cal on idle to tx/rx
    logic [IRQ_W-1:0] irq_status;     // sticky events
    logic [IRQ_W-1:0] irq_enable;     // event mask
    // bus handshake
    logic             ack;            // answer given this cycle
    logic             wr_take;        // write takes effect
    logic [7:0]       idx;            // register index
    logic [7:0]       wbyte;          // low write byte
    // timing
    logic [6:0]       us_cnt;         // microsecond divider
    logic             us_tick;        // one pulse per us
    logic [9:0]       ms_cnt;         // millisecond divider
    logic             ms_tick;        // one pulse per ms
    // sequencers
    syn_state_t       syn_state;
    rc_state_t        rc_state;
    logic [SETTLE_W-1:0] settle_cnt;  // settle time left in us
    logic [CNT_W-1:0] rc_cnt;         // rc cal time left in us
    logic [CNT_W-1:0] fine_cnt;       // ms elapsed in the fine cal period
    logic             wake_prev;      // previous wake condition
    logic             adc_prev;       // previous adc done
    // events
    logic             vco_force_go;   // accepted vco force write
    logic             rc_force_go;    // accepted rc force write
    logic             rc_start;       // any rc cal starts
    logic             rc_done;        // rc cal ends
    logic             settle_done;    // settling interval ends
    logic             wake_now;       // auto rc cal condition
    logic [IRQ_W-1:0] irq_set;        // events this cycle

    assign idx   = address[9:2];
    assign wbyte = writedata[7:0];

    // one wait cycle, answer at the second edge
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            ack <= 1'b0;
        end else begin
            ack <= (read | write) & ~ack;
        end
    end
    assign waitrequest = (read | write) & ~ack;
    assign wr_take     = write & ack & byteenable[0];

    // microsecond enable from mclk
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            us_cnt <= 7'h00;
        end else if (us_tick) begin
            us_cnt <= 7'h00;
        end else begin
            us_cnt <= us_cnt + 7'h01;
        end
    end
    assign us_tick = (us_cnt == 7'(US_DIV - 1));

    // millisecond enable from the us tick
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            ms_cnt <= 10'h000;
        end else if (ms_tick) begin
            ms_cnt <= 10'h000;
        end else if (us_tick) begin
            ms_cnt <= ms_cnt + 10'h001;
        end
    end
    assign ms_tick = us_tick & (ms_cnt == 10'(MS_US - 1));

    // plain read/write registers
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            tune_reg   <= TUNE_RST;
            boost_reg  <= BOOST_RST;
            xtal_half  <= CAL_RST[XHALF_BIT];
            fine_en    <= CAL_RST[FINE_BIT];
            vco_double <= CAL_RST[VDP_BIT];
            skip_vco   <= CAL_RST[SKIP_BIT];
            irq_enable <= '0;
        end else if (wr_take) begin
            unique case (idx)
                IDX_TUNE:       tune_reg  <= wbyte;
                IDX_BOOST:      boost_reg <= wbyte;
                IDX_CAL: begin
                    xtal_half  <= wbyte[XHALF_BIT];
                    fine_en    <= wbyte[FINE_BIT];
                    vco_double <= wbyte[VDP_BIT];
                    skip_vco   <= wbyte[SKIP_BIT];
                end
                IDX_IRQ_ENABLE: irq_enable <= wbyte[IRQ_W-1:0];
                default: ;          // unmapped writes ignored
            endcase
        end
    end

    // force writes that are accepted
    assign vco_force_go = wr_take & (idx == IDX_CAL) & wbyte[VCOCAL_BIT] & ~vco_force
                          & chip_state.chip_idle & chip_state.synth_enable
                          & (syn_state == SYN_IDLE);
    assign rc_force_go  = wr_take & (idx == IDX_CAL) & wbyte[RCCAL_BIT] & ~rc_force
                          & chip_state.rc_osc_enabled;

    // vco force held until cal ends
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            vco_force <= 1'b0;
        end else if (vco_force_go) begin
            vco_force <= 1'b1;
        end else if (syn_state == SYN_CAL && vco_cal_finished) begin
            vco_force <= 1'b0;
        end
    end

    // vco cal and settle sequencer
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            syn_state  <= SYN_IDLE;
            settle_cnt <= '0;
        end else begin
            unique case (syn_state)
                SYN_IDLE: begin
                    if (vco_force_go || (txrx_req && !skip_vco)) begin
                        syn_state <= SYN_CAL;
                    end else if (txrx_req || retune_req) begin
                        // no calibration: soft settle only
                        syn_state  <= SYN_SETTLE;
                        settle_cnt <= settle_us(tune_reg[TS_HI:TS_LO]);
                    end
                end
                SYN_CAL: begin
                    if (vco_cal_finished) begin
                        // cold start: soft plus post-cal time
                        syn_state  <= SYN_SETTLE;
                        settle_cnt <= settle_us(tune_reg[TS_HI:TS_LO])
                                    + settle_us({2'b00, tune_reg[TO_HI:TO_LO]});
                    end
                end
                SYN_SETTLE: begin
                    if (settle_cnt == '0) begin
                        syn_state <= SYN_IDLE;
                    end else if (us_tick) begin
                        settle_cnt <= settle_cnt - SETTLE_W'(1);
                    end
                end
                default: syn_state <= SYN_IDLE;
            endcase
        end
    end
    assign settle_done = (syn_state == SYN_SETTLE) && (settle_cnt == '0);

    // one start pulse per calibration
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            vco_cal_start <= 1'b0;
        end else begin
            vco_cal_start <= (syn_state == SYN_IDLE)
                             && (vco_force_go || (txrx_req && !skip_vco));
        end
    end

    // settled level
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            synth_settled <= 1'b0;
        end else if (settle_done) begin
            synth_settled <= 1'b1;
        end else if (syn_state != SYN_IDLE) begin
            synth_settled <= 1'b0;
        end
    end
    assign vco_cal_busy = (syn_state == SYN_CAL);

    // auto rc cal on wake entry
    assign wake_now = chip_state.wake_timer_en | chip_state.wake_on_rx;
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            wake_prev <= 1'b0;
            adc_prev  <= 1'b0;
        end else begin
            wake_prev <= wake_now;
            adc_prev  <= chip_state.adc_cal_finished;
        end
    end

    // fine calibration period counter
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            fine_cnt <= '0;
        end else if (!fine_en || !chip_state.rc_osc_enabled) begin
            fine_cnt <= '0;
        end else if (ms_tick) begin
            if (fine_cnt == CNT_W'(FINE_CAL_TICKS - 1)) begin
                fine_cnt <= '0;
            end else begin
                fine_cnt <= fine_cnt + CNT_W'(1);
            end
        end
    end

    // rc start, oscillator on only
    assign rc_start = (rc_state == RC_IDLE) && chip_state.rc_osc_enabled && (
                      rc_force_go || (wake_now && !wake_prev)
                      || (fine_en && ms_tick
                          && fine_cnt == CNT_W'(FINE_CAL_TICKS - 1)));
    assign rc_done  = (rc_state == RC_RUN) && (rc_cnt == '0);

    // rc oscillator calibration timer
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            rc_state    <= RC_IDLE;
            rc_cnt      <= '0;
            rc_cal_fine <= 1'b0;
        end else begin
            unique case (rc_state)
                RC_IDLE: begin
                    if (rc_start || (rc_force && chip_state.rc_osc_enabled)) begin
                        rc_state    <= RC_RUN;
                        rc_cnt      <= CNT_W'(RC_CAL_TICKS);
                        rc_cal_fine <= fine_en && !rc_force_go && !rc_force;
                    end
                end
                RC_RUN: begin
                    if (!chip_state.rc_osc_enabled || rc_cnt == '0) begin
                        rc_state    <= RC_IDLE;
                        rc_cal_fine <= 1'b0;
                    end else if (us_tick) begin
                        rc_cnt <= rc_cnt - CNT_W'(1);
                    end
                end
                default: rc_state <= RC_IDLE;
            endcase
        end
    end
    assign rc_cal_active = (rc_state == RC_RUN);

    // rc force: pending or running
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            rc_force <= 1'b0;
        end else if (rc_force_go) begin
            rc_force <= 1'b1;
        end else if (rc_done || !chip_state.rc_osc_enabled) begin
            rc_force <= 1'b0;
        end
    end

    // sticky status, set wins over clear
    assign irq_set[IRQ_VCO]     = (syn_state == SYN_CAL) && vco_cal_finished;
    assign irq_set[IRQ_RC]      = rc_done;
    assign irq_set[IRQ_SETTLED] = settle_done;
    assign irq_set[IRQ_ADC]     = chip_state.adc_cal_finished && !adc_prev;
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            irq_status <= '0;
        end else if (wr_take && idx == IDX_IRQ_CLEAR) begin
            irq_status <= (irq_status & ~wbyte[IRQ_W-1:0]) | irq_set;
        end else begin
            irq_status <= irq_status | irq_set;
        end
    end

    // level interrupt
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            irq <= 1'b0;
        end else begin
            irq <= |(irq_status & irq_enable);
        end
    end

    // read data, registered at the first edge, held for the answer
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            readdata <= 32'h0000_0000;
        end else if (read && !ack) begin
            unique case (idx)
                IDX_TUNE:       readdata <= {24'h00_0000, tune_reg};
                IDX_BOOST:      readdata <= {24'h00_0000, boost_reg};
                IDX_CAL:        readdata <= {24'h00_0000, 1'b0, xtal_half,
                                             chip_state.adc_cal_finished,
                                             fine_en, rc_force, vco_double,
                                             vco_force, skip_vco};
                IDX_IRQ_STATUS: readdata <= {28'h000_0000, irq_status};
                IDX_IRQ_ENABLE: readdata <= {28'h000_0000, irq_enable};
                default:        readdata <= 32'h0000_0000; // unmapped and clear
            endcase
        end
    end

    // analog steering, straight from registers
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            analog_ctrl <= '0;
        end else begin
            analog_ctrl.xtal_wake_half       <= xtal_half;
            analog_ctrl.amp_regulator_boost  <= boost_reg[REGB_BIT];
            analog_ctrl.amp_bias_boost       <= boost_reg[BIAS_BIT];
            analog_ctrl.preamble_window_bits <=
                6'(boost_reg[PRE_HI:PRE_LO] * PRE_MULT);
            analog_ctrl.skip_vco_cal         <= skip_vco;
            analog_ctrl.vco_cal_double       <= vco_double;
        end
    end

endmodule
`default_nettype wire

// File: verification/pll_tune_and_calibration_ctrl_properties.sv
`default_nettype none
module pll_cal_properties
    import pll_cal_pkg::*;
#(
    parameter int US_DIV       = US_CYCLES,
    parameter int RC_CAL_TICKS = RC_CAL_US
) (
    // clock, reset and bus
    input wire logic         mclk,
    input wire logic         rst_n,
    input wire logic [9:0]   address,
    input wire logic         read,
    input wire logic         write,
    input wire logic [31:0]  writedata,
    input wire logic [3:0]   byteenable,
    input wire logic [31:0]  readdata,
    input wire logic         waitrequest,
    // chip side
    input wire chip_state_t  chip_state,
    input wire logic         vco_cal_finished,
    input wire analog_ctrl_t analog_ctrl,
    input wire logic         vco_cal_start,
    input wire logic         vco_cal_busy,
    input wire logic         synth_settled,
    input wire logic         rc_cal_active
);
    timeunit 1ns;
    timeprecision 1ps;
    logic       wr_eff;   // write takes effect
    logic [7:0] idx;      // register index of the request
    logic [7:0] wd_q;     // last written byte
    logic [7:0] tune_sh;  // tune register shadow
    logic       set_run;  // timing a cold start
    int         set_cnt;  // cycles since vco cal finished
    int         set_t;    // expected settling in cycles
    int         rc_cnt;   // cycles of rc cal activity
    assign wr_eff = write && !waitrequest && byteenable[0];
    assign idx    = address[9:2];
    assign set_t  = (int'(tune_sh[7:3]) + int'(tune_sh[2:0])) * SETTLE_STEP_US * US_DIV;
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rst_n);
    // shadow registers follow effective writes
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            tune_sh <= TUNE_RST;
        end else if (wr_eff) begin
            wd_q <= writedata[7:0];
            if (idx == IDX_TUNE) tune_sh <= writedata[7:0];
        end
    end
    // cold start and rc timers
    always_ff @(posedge mclk) begin
        set_cnt <= (vco_cal_busy && vco_cal_finished) ? 0 : set_cnt + 1;
        if (!rst_n || synth_settled) set_run <= 1'b0;
        else if (vco_cal_busy && vco_cal_finished) set_run <= 1'b1;
        rc_cnt <= (!rst_n || !rc_cal_active) ? 0 : rc_cnt + 1;
    end
    chk_window_follows: assert property (wr_eff && idx == IDX_BOOST |-> ##2
        analog_ctrl.preamble_window_bits == {wd_q[5:2], 2'b00}) else $error("window wrong");
    chk_cal_bits_follow: assert property (wr_eff && idx == IDX_CAL |-> ##2
        {analog_ctrl.xtal_wake_half, analog_ctrl.vco_cal_double, analog_ctrl.skip_vco_cal}
        == {wd_q[XHALF_BIT], wd_q[VDP_BIT], wd_q[SKIP_BIT]}) else $error("cal bits wrong");
    chk_adc_done_read: assert property (read && !waitrequest && idx == IDX_CAL
        && $stable(chip_state.adc_cal_finished)
        |-> readdata[ADCDONE_BIT] == chip_state.adc_cal_finished) else $error("adc done wrong");
    chk_vco_start_busy: assert property ($rose(vco_cal_busy)
        |-> vco_cal_start ##1 !vco_cal_start) else $error("vco start pulse wrong");
    chk_vco_force_gate: assert property (wr_eff && idx == IDX_CAL && writedata[VCOCAL_BIT]
        && !(chip_state.chip_idle && chip_state.synth_enable) |=> !vco_cal_start)
        else $error("vco cal started outside idle");
    chk_settle_length: assert property ($rose(synth_settled) && set_run
        |-> set_cnt >= set_t - US_DIV && set_cnt <= set_t + US_DIV + 2)
        else $error("settling time wrong");
    chk_rc_force_start: assert property (wr_eff && idx == IDX_CAL && writedata[RCCAL_BIT]
        && chip_state.rc_osc_enabled && !rc_cal_active |-> ##[1:2] rc_cal_active)
        else $error("rc cal not started");
    chk_rc_length: assert property ($fell(rc_cal_active) && chip_state.rc_osc_enabled
        |-> rc_cnt >= (RC_CAL_TICKS - 1) * US_DIV && rc_cnt <= RC_CAL_TICKS * US_DIV + 1)
        else $error("rc cal length wrong");
    chk_rc_needs_osc: assert property (!chip_state.rc_osc_enabled ##1
        !chip_state.rc_osc_enabled |-> !rc_cal_active) else $error("rc cal without oscillator");
    // main scenarios reached
    cover property ($rose(synth_settled) && set_run);
    cover property ($fell(rc_cal_active) && chip_state.rc_osc_enabled);
    cover property (vco_cal_start);
endmodule
bind pll_tune_and_calibration_ctrl pll_cal_properties #(
    .US_DIV(US_DIV), .RC_CAL_TICKS(RC_CAL_TICKS)
) u_props (
    .mclk, .rst_n, .address, .read, .write, .writedata, .byteenable, .readdata, .waitrequest,
    .chip_state, .vco_cal_finished, .analog_ctrl, .vco_cal_start, .vco_cal_busy,
    .synth_settled, .rc_cal_active
);
`default_nettype wire

// File: verification/tb_pll_tune_and_calibration_ctrl.sv
`default_nettype none
module tb_pll_tune_and_calibration_ctrl
    import pll_cal_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int US = 4;  // shortened microsecond divider
    logic         mclk, rst_n, read, write, txrx_req, retune_req, vco_cal_finished;
    logic [9:0]   address;
    logic [31:0]  writedata, readdata;
    logic [3:0]   byteenable;
    logic         waitrequest, vco_cal_start, vco_cal_busy, synth_settled;
    logic         rc_cal_active, rc_cal_fine, irq;
    chip_state_t  chip_state;
    analog_ctrl_t analog_ctrl;
    int           err_total, comparisons;
    pll_tune_and_calibration_ctrl #(.US_DIV(US), .RC_CAL_TICKS(3), .FINE_CAL_TICKS(2)) uut (
        .mclk, .rst_n, .address, .read, .write, .writedata, .byteenable, .readdata,
        .waitrequest, .chip_state, .txrx_req, .retune_req, .vco_cal_finished, .analog_ctrl,
        .vco_cal_start, .vco_cal_busy, .synth_settled, .rc_cal_active, .rc_cal_fine, .irq
    );
    // 125 MHz clock
    always #4 mclk = ~mclk;
    // compare and count
    task automatic check(input logic [31:0] seen, exp);
        comparisons++;
        if (seen !== exp) begin
            err_total++;
            $display("BAD t=%0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    // one avalon transfer
    task automatic bus(input logic wr, input logic [7:0] idx, input logic [7:0] d,
                       input logic [3:0] be, output logic [31:0] q);
        int n = 0;
        address <= {idx, 2'b00};
        writedata <= 32'(d);
        byteenable <= be;
        write <= wr;
        read <= !wr;
        do begin
            @(posedge mclk);
            n++;
        end while (waitrequest !== 1'b0 && n < 50);
        if (n >= 50) err_total++;
        q = readdata;
        write <= 1'b0;
        read <= 1'b0;
        @(posedge mclk);
    endtask
    task automatic wr(input logic [7:0] idx, input logic [7:0] d);
        logic [31:0] q;
        bus(1'b1, idx, d, 4'hF, q);
    endtask
    task automatic rd(input logic [7:0] idx, input logic [7:0] exp);
        logic [31:0] q;
        bus(1'b0, idx, 8'h00, 4'hF, q);
        check(q, 32'(exp));
    endtask
    // wait for a level, n = lim on timeout
    task automatic wait_sig(input int sel, input logic lvl, input int lim, output int n);
        logic v;
        n = 0;
        do begin
            @(posedge mclk);
            n++;
            case (sel)
                0: v = vco_cal_start;
                1: v = synth_settled;
                2: v = rc_cal_active;
                default: v = rc_cal_fine;
            endcase
        end while (v !== lvl && n < lim);
        if (v !== lvl) n = lim;
    endtask
    // one-cycle pulse on a sequencer input
    task automatic pulse(input int sel);
        case (sel)
            0: vco_cal_finished <= 1'b1;
            1: txrx_req <= 1'b1;
            default: retune_req <= 1'b1;
        endcase
        @(posedge mclk);
        vco_cal_finished <= 1'b0;
        txrx_req <= 1'b0;
        retune_req <= 1'b0;
    endtask
    // reset values, unmapped read, adc done bit
    task automatic t_reset;
        rd(IDX_TUNE, TUNE_RST);
        rd(IDX_BOOST, BOOST_RST);
        rd(IDX_CAL, CAL_RST);
        rd(8'h70, 8'h00);
        check(analog_ctrl, {1'b1, 1'b0, 1'b0, 6'h14, 1'b0, 1'b1});
        chip_state.adc_cal_finished <= 1'b1;
        @(posedge mclk);
        rd(IDX_CAL, 8'h64);
    endtask
    // field writes and masked byte
    task automatic t_fields;
        logic [31:0] q;
        wr(IDX_BOOST, 8'hFF);
        rd(IDX_BOOST, 8'hFF);
        wr(IDX_CAL, 8'h41);
        rd(IDX_CAL, 8'h61);
        check(analog_ctrl, {1'b1, 1'b1, 1'b1, 6'h3C, 1'b1, 1'b0});
        bus(1'b1, IDX_TUNE, 8'h00, 4'hE, q);
        rd(IDX_TUNE, TUNE_RST);
        wr(IDX_CAL, 8'h04);
        rd(IDX_CAL, 8'h24);
    endtask
    // forced vco cal, timed settling, refusal and skip
    task automatic t_vco;
        int n;
        chip_state.chip_idle <= 1'b1;
        chip_state.synth_enable <= 1'b1;
        wr(IDX_TUNE, 8'h11);
        wr(IDX_CAL, 8'h06);
        check(vco_cal_busy, 1'b1);
        rd(IDX_CAL, 8'h26);
        check(synth_settled, 1'b0);
        pulse(0);
        wait_sig(1, 1'b1, 400, n);
        check(n >= 29 * US && n <= 31 * US + 2, 1'b1);
        rd(IDX_CAL, 8'h24);
        rd(IDX_IRQ_STATUS, 8'h0D);
        wr(IDX_TUNE, 8'h00);
        pulse(2);
        wait_sig(1, 1'b1, US + 3, n);
        check(n < US + 3, 1'b1);
        chip_state.chip_idle <= 1'b0;
        wr(IDX_CAL, 8'h06);
        check(vco_cal_busy, 1'b0);
        rd(IDX_CAL, 8'h24);
        chip_state.chip_idle <= 1'b1;
        wr(IDX_CAL, 8'h01);
        pulse(1);
        wait_sig(1, 1'b1, 8, n);
        check(vco_cal_busy, 1'b0);
        wr(IDX_CAL, 8'h00);
        pulse(1);
        @(posedge mclk);
        check(vco_cal_busy, 1'b1);
        pulse(0);
        wait_sig(1, 1'b1, 8, n);
    endtask
    // rc cal: gate, force, auto, abort, fine
    task automatic t_rc;
        int n;
        wr(IDX_CAL, 8'h08);
        check(rc_cal_active, 1'b0);
        rd(IDX_CAL, 8'h20);
        chip_state.rc_osc_enabled <= 1'b1;
        wr(IDX_CAL, 8'h08);
        rd(IDX_CAL, 8'h28);
        check(rc_cal_active, 1'b1);
        wait_sig(2, 1'b0, 40, n);
        check(n < 40, 1'b1);
        rd(IDX_CAL, 8'h20);
        chip_state.wake_timer_en <= 1'b1;
        wait_sig(2, 1'b1, 4, n);
        check(n < 4, 1'b1);
        wait_sig(2, 1'b0, 40, n);
        chip_state.wake_timer_en <= 1'b0;
        wr(IDX_CAL, 8'h08);
        chip_state.rc_osc_enabled <= 1'b0;
        wait_sig(2, 1'b0, 3, n);
        check(n < 3, 1'b1);
        chip_state.rc_osc_enabled <= 1'b1;
        wr(IDX_CAL, 8'h10);
        wait_sig(3, 1'b1, 10000, n);
        check(n < 10000, 1'b1);
        wr(IDX_CAL, 8'h00);
    endtask
    // enable, mask and clear of the interrupt
    task automatic t_irq;
        repeat (20) @(posedge mclk);
        wr(IDX_IRQ_ENABLE, 8'h02);
        rd(IDX_IRQ_ENABLE, 8'h02);
        check(irq, 1'b1);
        wr(IDX_IRQ_ENABLE, 8'h00);
        @(posedge mclk);
        check(irq, 1'b0);
        wr(IDX_IRQ_CLEAR, 8'h0F);
        rd(IDX_IRQ_STATUS, 8'h00);
        rd(IDX_IRQ_CLEAR, 8'h00);
        wr(IDX_IRQ_ENABLE, 8'h02);
        @(posedge mclk);
        check(irq, 1'b0);
    endtask
    // verdict and end of run
    task automatic tally_and_finish;
        if (err_total == 0 && comparisons > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask
    // hang guard
    initial begin
        repeat (40000) @(posedge mclk);
        err_total++;
        tally_and_finish();
    end
    // main sequence
    initial begin
        mclk = 1'b0;
        rst_n = 1'b0;
        {read, write, txrx_req, retune_req, vco_cal_finished} = 5'h00;
        address = '0;
        writedata = '0;
        byteenable = 4'h0;
        chip_state = '0;
        err_total = 0;
        comparisons = 0;
        repeat (5) @(posedge mclk);
        rst_n <= 1'b1;
        @(posedge mclk);
        t_reset();
        t_fields();
        t_vco();
        t_rc();
        t_irq();
        tally_and_finish();
    end
endmodule
`default_nettype wire
